// *** src/fconv_pkg.sv ***
package fconv_pkg;
    // ***********************************************
    // register map (byte addresses, one word each)
    // ***********************************************
    localparam logic [7:0] CTRL_OFFSET = 8'h00;
    localparam logic [7:0] SRC_LO_OFFSET = 8'h04;
    localparam logic [7:0] SRC_HI_OFFSET = 8'h08;
    localparam logic [7:0] RESULT_OFFSET = 8'h0c;
    localparam logic [7:0] FLAGS_OFFSET = 8'h10;
    localparam logic [7:0] ERROR_CODE_OFFSET = 8'h14;
    localparam logic [7:0] IRQ_STATUS_OFFSET = 8'h18;
    localparam logic [7:0] IRQ_MASK_OFFSET = 8'h1c;

    // ***********************************************
    // field positions
    // ***********************************************
    localparam int CTRL_OP_LSB = 0;
    localparam int CTRL_OP_MSB = 2;
    localparam int CTRL_PULSE_BIT = 3;
    localparam int CTRL_ENABLE_BIT = 4;
    localparam int FLAG_ZERO_BIT = 0;
    localparam int FLAG_TRUNC_BIT = 1;
    localparam int FLAG_OVERFLOW_BIT = 2;
    localparam int IRQ_DONE_BIT = 0;
    localparam int IRQ_OVERFLOW_BIT = 1;
    localparam int IRQ_ERROR_BIT = 2;
    localparam int IRQ_WIDTH = 3;

    // ***********************************************
    // reset values and codes
    // ***********************************************
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] DATA_RESET = 32'h0000_0000;
    localparam logic [2:0] IRQ_MASK_RESET = 3'h0;
    localparam logic [15:0] RANGE_ERROR_CODE = 16'h2013;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ***********************************************
    // float layouts and integer limits
    // ***********************************************
    localparam int SINGLE_BIAS = 127;
    localparam int DOUBLE_BIAS = 1023;
    localparam logic [7:0] SINGLE_EXP_ALL_ONES = 8'hff;
    localparam logic [10:0] DOUBLE_EXP_ALL_ONES = 11'h7ff;
    localparam int FRAC_POINT = 52;
    localparam logic [63:0] SHORT_POS_LIMIT = 64'h0000_0000_0000_7fff;
    localparam logic [63:0] SHORT_NEG_LIMIT = 64'h0000_0000_0000_8000;
    localparam logic [63:0] LONG_POS_LIMIT = 64'h0000_0000_7fff_ffff;
    localparam logic [63:0] LONG_NEG_LIMIT = 64'h0000_0000_8000_0000;

    // ***********************************************
    // scan timing
    // ***********************************************
    localparam int CLOCK_PERIOD_NS = 4;
    localparam int SCAN_PERIOD_NS = 1000;
    localparam int SCAN_CYCLES = (SCAN_PERIOD_NS / CLOCK_PERIOD_NS < 1) ? 1 : SCAN_PERIOD_NS / CLOCK_PERIOD_NS;

    typedef enum logic [2:0] {
        OP_SINGLE_TO_SHORT,
        OP_SINGLE_TO_LONG,
        OP_DOUBLE_TO_SHORT,
        OP_DOUBLE_TO_LONG,
        OP_SIGN_EXTEND,
        OP_NARROW
    } op_t;
endpackage

// *** src/float_to_int_and_width_convert.sv ***
// The implementer's own choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ns
// Behaviour
// [RQ1] single source infinite or NaN: skip, raise error flag, load error code 2013
// [RQ2] single source converts to 16-bit or 32-bit integer, fraction truncated
// [RQ3] double source converts to integer by dropping the fraction
// [RQ4] narrow double conversion reads four 16-bit words, writes one word
// [RQ5] wide double conversion reads four 16-bit words, writes two words
// [RQ6] program must not name a 32-bit counter as narrow destination
// [RQ7] zero flag set when the converted integer is zero
// [RQ8] truncation flag set when a nonzero fraction was discarded
// [RQ9] overflow flag set when the integer misses the destination range
// [RQ10] narrow double range is -32768 to 32767
// [RQ11] wide double range is -2147483648 to 2147483647
// [RQ12] sign extend copies 16 bits low and bit 15 into bits 15..31
// [RQ13] sign extend exists only as a 16-bit pulse operation
// [RQ14] narrowing move keeps the sign of the 32-bit source
// [RQ15] narrowing: bit 31 to bit 15, bits 0..14 kept, 15..30 dropped
// [RQ16] double conversion inverts the four-word integer-to-double layout
// [RQ17] pulse form runs once, on the scan where enable turns on
// [RQ18] plain form runs each scan while enabled, else leaves all untouched
module float_to_int_and_width_convert #(
    parameter int SCAN_DIVIDE = fconv_pkg::SCAN_CYCLES
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic awvalid_i,
    output logic awready_o,
    input wire logic [7:0] awaddr_i,
    input wire logic [2:0] awprot_i,
    input wire logic wvalid_i,
    output logic wready_o,
    input wire logic [31:0] wdata_i,
    input wire logic [3:0] wstrb_i,
    output logic bvalid_o,
    input wire logic bready_i,
    output logic [1:0] bresp_o,
    input wire logic arvalid_i,
    output logic arready_o,
    input wire logic [7:0] araddr_i,
    input wire logic [2:0] arprot_i,
    output logic rvalid_o,
    input wire logic rready_i,
    output logic [31:0] rdata_o,
    output logic [1:0] rresp_o,
    output logic zero_result_flag_o,
    output logic truncation_flag_o,
    output logic overflow_flag_o,
    output logic operation_error_flag_o,
    output logic interrupt_o
);
    import fconv_pkg::*;

    // ***********************************************
    // helpers
    // ***********************************************
    function automatic logic [31:0] apply_strobe(input logic [31:0] old_value, input logic [31:0] new_value,
                                                 input logic [3:0] strobe);
        logic [31:0] merged;
        merged = old_value;
        for (int i = 0; i < 4; i++) begin
            if (strobe[i]) begin
                merged[i*8 +: 8] = new_value[i*8 +: 8];
            end
        end
        return merged;
    endfunction

    // {overflow, truncated, value}; unbiased exponent, 53-bit mantissa with hidden bit
    function automatic logic [33:0] float_to_int(input logic sign, input logic signed [12:0] exponent,
                                                 input logic [52:0] mantissa, input logic wide);
        logic [63:0] magnitude;
        logic [63:0] lost;
        logic [63:0] limit;
        logic ovf;
        logic trunc;
        logic [31:0] value;
        magnitude = 64'h0;
        lost = 64'h0;
        ovf = 1'b0;
        trunc = 1'b0;
        value = 32'h0;
        if (exponent < 0) begin
            trunc = |mantissa;
        end else if (exponent > 13'sd32) begin
            ovf = 1'b1;
        end else begin
            magnitude = {11'h0, mantissa} >> (FRAC_POINT - int'(exponent));
            lost = {11'h0, mantissa} & ((64'h1 << (FRAC_POINT - int'(exponent))) - 64'h1);
            trunc = |lost;
        end
        if (wide) begin
            limit = sign ? LONG_NEG_LIMIT : LONG_POS_LIMIT;
        end else begin
            limit = sign ? SHORT_NEG_LIMIT : SHORT_POS_LIMIT;
        end
        if (magnitude > limit) begin
            ovf = 1'b1;
        end
        value = sign ? 32'(64'h0 - magnitude) : magnitude[31:0];
        if (!wide) begin
            value = {16'h0, value[15:0]};
        end
        return {ovf, trunc, value};
    endfunction

    // ***********************************************
    // register state
    // ***********************************************
    logic [31:0] ctrl_reg;
    logic [31:0] src_lo_reg;
    logic [31:0] src_hi_reg;
    logic [31:0] result_reg;
    logic [2:0] flags_reg;
    logic [15:0] error_code_reg;
    logic [IRQ_WIDTH-1:0] irq_status_reg;
    logic [IRQ_WIDTH-1:0] irq_mask_reg;

    // ***********************************************
    // write channel
    // ***********************************************
    logic aw_held_reg;
    logic w_held_reg;
    logic [7:0] waddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic do_write;
    logic write_mapped;

    assign do_write = aw_held_reg && w_held_reg && !bvalid_o;
    assign write_mapped = (waddr_reg[7:5] == 3'h0) && (waddr_reg[1:0] == 2'h0);

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            aw_held_reg <= 1'b0;
            awready_o <= 1'b1;
            waddr_reg <= 8'h0;
        end else if (awvalid_i && awready_o) begin
            aw_held_reg <= 1'b1;
            awready_o <= 1'b0;
            waddr_reg <= awaddr_i;
        end else if (do_write) begin
            aw_held_reg <= 1'b0;
        end else if (bvalid_o && bready_i) begin
            awready_o <= 1'b1;
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            w_held_reg <= 1'b0;
            wready_o <= 1'b1;
            wdata_reg <= 32'h0;
            wstrb_reg <= 4'h0;
        end else if (wvalid_i && wready_o) begin
            w_held_reg <= 1'b1;
            wready_o <= 1'b0;
            wdata_reg <= wdata_i;
            wstrb_reg <= wstrb_i;
        end else if (do_write) begin
            w_held_reg <= 1'b0;
        end else if (bvalid_o && bready_i) begin
            wready_o <= 1'b1;
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            bvalid_o <= 1'b0;
            bresp_o <= RESP_OKAY;
        end else if (do_write) begin
            bvalid_o <= 1'b1;
            bresp_o <= write_mapped ? RESP_OKAY : RESP_SLVERR;
        end else if (bvalid_o && bready_i) begin
            bvalid_o <= 1'b0;
        end
    end

    // ***********************************************
    // read channel
    // ***********************************************
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            arready_o <= 1'b1;
            rvalid_o <= 1'b0;
            rdata_o <= 32'h0;
            rresp_o <= RESP_OKAY;
        end else if (arvalid_i && arready_o) begin
            arready_o <= 1'b0;
            rvalid_o <= 1'b1;
            rresp_o <= RESP_OKAY;
            unique case (araddr_i)
                CTRL_OFFSET: rdata_o <= ctrl_reg;
                SRC_LO_OFFSET: rdata_o <= src_lo_reg;
                SRC_HI_OFFSET: rdata_o <= src_hi_reg;
                RESULT_OFFSET: rdata_o <= result_reg;
                FLAGS_OFFSET: rdata_o <= {29'h0, flags_reg};
                ERROR_CODE_OFFSET: rdata_o <= {16'h0, error_code_reg};
                IRQ_STATUS_OFFSET: rdata_o <= {29'h0, irq_status_reg};
                IRQ_MASK_OFFSET: rdata_o <= {29'h0, irq_mask_reg};
                default: begin
                    rdata_o <= 32'h0;
                    rresp_o <= RESP_SLVERR;
                end
            endcase
        end else if (rvalid_o && rready_i) begin
            rvalid_o <= 1'b0;
            arready_o <= 1'b1;
        end
    end

    // ***********************************************
    // software-written registers
    // ***********************************************
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            ctrl_reg <= CTRL_RESET;
            src_lo_reg <= DATA_RESET;
            src_hi_reg <= DATA_RESET;
            irq_mask_reg <= IRQ_MASK_RESET;
        end else if (do_write) begin
            unique case (waddr_reg)
                CTRL_OFFSET: ctrl_reg <= apply_strobe(ctrl_reg, wdata_reg, wstrb_reg) & 32'h0000_001f;
                SRC_LO_OFFSET: src_lo_reg <= apply_strobe(src_lo_reg, wdata_reg, wstrb_reg);
                SRC_HI_OFFSET: src_hi_reg <= apply_strobe(src_hi_reg, wdata_reg, wstrb_reg);
                IRQ_MASK_OFFSET: irq_mask_reg <= wstrb_reg[0] ? wdata_reg[IRQ_WIDTH-1:0] : irq_mask_reg;
                default: begin
                end
            endcase
        end
    end

    // ***********************************************
    // scan divider and enable edge
    // ***********************************************
    logic [$clog2(SCAN_DIVIDE+1)-1:0] scan_count_reg;
    logic scan_tick_reg;
    logic enable_prev_reg;
    op_t op;
    logic pulse_form;
    logic execute;

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            scan_count_reg <= '0;
            scan_tick_reg <= 1'b0;
        end else if (scan_count_reg == ($clog2(SCAN_DIVIDE+1))'(SCAN_DIVIDE - 1)) begin
            scan_count_reg <= '0;
            scan_tick_reg <= 1'b1;
        end else begin
            scan_count_reg <= scan_count_reg + 1'b1;
            scan_tick_reg <= 1'b0;
        end
    end

    assign op = op_t'(ctrl_reg[CTRL_OP_MSB:CTRL_OP_LSB]);
    // sign extend has no plain form, so it is always edge triggered
    assign pulse_form = ctrl_reg[CTRL_PULSE_BIT] || (op == OP_SIGN_EXTEND); // [RQ13]
    assign execute = scan_tick_reg && ctrl_reg[CTRL_ENABLE_BIT]
                     && (!pulse_form || !enable_prev_reg); // [RQ17] [RQ18]

    // edge seen only at scan boundaries, like a program scan sampling its contact
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            enable_prev_reg <= 1'b0;
        end else if (scan_tick_reg) begin
            enable_prev_reg <= ctrl_reg[CTRL_ENABLE_BIT];
        end
    end

    // ***********************************************
    // conversion datapath
    // ***********************************************
    logic [63:0] double_src;
    logic [33:0] single_conv;
    logic [33:0] double_conv;
    logic single_range_error;
    logic double_special;
    logic [12:0] single_exp;
    logic [12:0] double_exp;

    // four 16-bit words, lowest word first, same layout integer-to-double writes
    assign double_src = {src_hi_reg, src_lo_reg}; // [RQ4] [RQ5] [RQ16]
    assign single_exp = 13'(signed'({5'h0, src_lo_reg[30:23]}) - 13'(SINGLE_BIAS));
    assign double_exp = 13'(signed'({2'h0, double_src[62:52]}) - 13'(DOUBLE_BIAS));
    assign single_range_error = (src_lo_reg[30:23] == SINGLE_EXP_ALL_ONES); // [RQ1]
    assign double_special = (double_src[62:52] == DOUBLE_EXP_ALL_ONES);

    // zero exponent field (zero and subnormal) falls below one and truncates to zero
    assign single_conv = float_to_int(src_lo_reg[31], (src_lo_reg[30:23] == 8'h0) ? -13'sd1 : signed'(single_exp),
                                      {(src_lo_reg[30:23] != 8'h0), src_lo_reg[22:0], 29'h0},
                                      op == OP_SINGLE_TO_LONG); // [RQ2]
    assign double_conv = float_to_int(double_src[63], (double_src[62:52] == 11'h0) ? -13'sd1 : signed'(double_exp),
                                      {(double_src[62:52] != 11'h0), double_src[51:0]},
                                      op == OP_DOUBLE_TO_LONG); // [RQ3] [RQ10] [RQ11]

    // ***********************************************
    // execution: result, flags, error code
    // ***********************************************
    logic [33:0] chosen_conv;
    logic float_op;
    logic error_now;
    logic overflow_now;

    assign float_op = (op == OP_SINGLE_TO_SHORT) || (op == OP_SINGLE_TO_LONG)
                      || (op == OP_DOUBLE_TO_SHORT) || (op == OP_DOUBLE_TO_LONG);
    assign chosen_conv = (op == OP_DOUBLE_TO_SHORT || op == OP_DOUBLE_TO_LONG) ? double_conv : single_conv;
    assign error_now = execute && (op == OP_SINGLE_TO_SHORT || op == OP_SINGLE_TO_LONG) && single_range_error;
    // infinite or NaN double sources have no error code; they report overflow instead
    assign overflow_now = execute && float_op && !error_now
                          && (chosen_conv[33] || (double_special && op inside {OP_DOUBLE_TO_SHORT, OP_DOUBLE_TO_LONG}));

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            result_reg <= DATA_RESET;
        end else if (execute) begin
            unique case (op)
                OP_SINGLE_TO_SHORT, OP_SINGLE_TO_LONG, OP_DOUBLE_TO_SHORT, OP_DOUBLE_TO_LONG: begin
                    // an out-of-range result leaves the destination as it was
                    if (!error_now && !overflow_now) begin
                        result_reg <= chosen_conv[31:0]; // [RQ2] [RQ3] [RQ4] [RQ5]
                    end
                end
                OP_SIGN_EXTEND: result_reg <= {{16{src_lo_reg[15]}}, src_lo_reg[15:0]}; // [RQ12]
                OP_NARROW: result_reg <= {16'h0, src_lo_reg[31], src_lo_reg[14:0]}; // [RQ14] [RQ15]
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            flags_reg <= 3'h0;
        end else if (execute && float_op && !error_now) begin
            flags_reg[FLAG_ZERO_BIT] <= !overflow_now && (chosen_conv[31:0] == 32'h0); // [RQ7]
            flags_reg[FLAG_TRUNC_BIT] <= chosen_conv[32]; // [RQ8]
            flags_reg[FLAG_OVERFLOW_BIT] <= overflow_now; // [RQ9]
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            error_code_reg <= 16'h0;
        end else if (error_now) begin
            error_code_reg <= RANGE_ERROR_CODE; // [RQ1]
        end
    end

    // ***********************************************
    // interrupt status: sticky, write one to clear
    // ***********************************************
    logic [IRQ_WIDTH-1:0] irq_set;
    logic [IRQ_WIDTH-1:0] irq_clear;

    assign irq_set = {error_now, overflow_now, execute && !error_now};
    assign irq_clear = (do_write && waddr_reg == IRQ_STATUS_OFFSET && wstrb_reg[0])
                       ? wdata_reg[IRQ_WIDTH-1:0] : '0;

    // a set in the clearing cycle wins so no event is lost
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            irq_status_reg <= '0;
        end else begin
            irq_status_reg <= (irq_status_reg & ~irq_clear) | irq_set;
        end
    end

    // ***********************************************
    // registered outputs
    // ***********************************************
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            zero_result_flag_o <= 1'b0;
            truncation_flag_o <= 1'b0;
            overflow_flag_o <= 1'b0;
            operation_error_flag_o <= 1'b0;
            interrupt_o <= 1'b0;
        end else begin
            zero_result_flag_o <= flags_reg[FLAG_ZERO_BIT];
            truncation_flag_o <= flags_reg[FLAG_TRUNC_BIT];
            overflow_flag_o <= flags_reg[FLAG_OVERFLOW_BIT];
            operation_error_flag_o <= irq_status_reg[IRQ_ERROR_BIT];
            interrupt_o <= |(irq_status_reg & irq_mask_reg);
        end
    end
endmodule

// *** tb/fconv_chk.sv ***
`timescale 1ns/1ns
module fconv_chk
    import fconv_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic awvalid_i,
    input wire logic awready_o,
    input wire logic wvalid_i,
    input wire logic wready_o,
    input wire logic bvalid_o,
    input wire logic bready_i,
    input wire logic [1:0] bresp_o,
    input wire logic arvalid_i,
    input wire logic arready_o,
    input wire logic rvalid_o,
    input wire logic rready_i,
    input wire logic [31:0] rdata_o,
    input wire logic [1:0] rresp_o,
    input wire logic zero_result_flag_o,
    input wire logic overflow_flag_o,
    input wire logic operation_error_flag_o,
    input wire logic interrupt_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);
    sequence s_write_taken;
        awvalid_i && awready_o && wvalid_i && wready_o;
    endsequence
    sequence s_b_accept;
        bvalid_o && bready_i;
    endsequence
    a_write_answer: assert property (s_write_taken |=> !awready_o && !wready_o ##1 bvalid_o)
        else $error("write response late");
    a_b_hold: assert property (bvalid_o && !bready_i |=> bvalid_o && $stable(bresp_o))
        else $error("write response dropped");
    a_ready_back: assert property (s_b_accept |=> !bvalid_o && awready_o && wready_o)
        else $error("write channel not reopened");
    a_read_answer: assert property (arvalid_i && arready_o |=> rvalid_o && !arready_o)
        else $error("read answer late");
    a_r_hold: assert property (rvalid_o && !rready_i |=> rvalid_o && $stable(rdata_o) && $stable(rresp_o))
        else $error("read answer dropped");
    a_resp_legal: assert property (bvalid_o |-> bresp_o == RESP_OKAY || bresp_o == RESP_SLVERR)
        else $error("bad write response code");
    a_ovf_not_zero: assert property (overflow_flag_o |-> !zero_result_flag_o)
        else $error("overflow with zero flag");
    a_reset_quiet: assert property ($past(rst_i) |-> !bvalid_o && !rvalid_o && !interrupt_o
        && !operation_error_flag_o && !overflow_flag_o)
        else $error("outputs busy after reset");
endmodule
bind float_to_int_and_width_convert fconv_chk chk_u(.clock_i(clock_i), .rst_i(rst_i),
    .awvalid_i(awvalid_i), .awready_o(awready_o), .wvalid_i(wvalid_i), .wready_o(wready_o),
    .bvalid_o(bvalid_o), .bready_i(bready_i), .bresp_o(bresp_o), .arvalid_i(arvalid_i),
    .arready_o(arready_o), .rvalid_o(rvalid_o), .rready_i(rready_i), .rdata_o(rdata_o),
    .rresp_o(rresp_o), .zero_result_flag_o(zero_result_flag_o), .overflow_flag_o(overflow_flag_o),
    .operation_error_flag_o(operation_error_flag_o), .interrupt_o(interrupt_o));

// *** tb/float_to_int_and_width_convert_test.sv ***
`timescale 1ns/1ns
module float_to_int_and_width_convert_test;
    import fconv_pkg::*;
    // short scan so each execution settles in a few cycles
    localparam int SD = 4;
    localparam int RW = 3 * SD + 4;
    logic clock_i, rst_i, awvalid_i, wvalid_i, bready_i, arvalid_i, rready_i;
    logic awready_o, wready_o, bvalid_o, arready_o, rvalid_o, interrupt_o;
    logic zero_result_flag_o, truncation_flag_o, overflow_flag_o, operation_error_flag_o;
    logic [7:0] awaddr_i, araddr_i;
    logic [31:0] wdata_i, rdata_o, rd;
    logic [3:0] wstrb_i;
    logic [1:0] bresp_o, rresp_o, resp;
    int errors = 0;
    int cmp_count = 0;
    int cycles = 0;
    float_to_int_and_width_convert #(.SCAN_DIVIDE(SD)) dut_u(.clock_i(clock_i), .rst_i(rst_i),
        .awvalid_i(awvalid_i), .awready_o(awready_o), .awaddr_i(awaddr_i), .awprot_i(3'h0),
        .wvalid_i(wvalid_i), .wready_o(wready_o), .wdata_i(wdata_i), .wstrb_i(wstrb_i),
        .bvalid_o(bvalid_o), .bready_i(bready_i), .bresp_o(bresp_o), .arvalid_i(arvalid_i),
        .arready_o(arready_o), .araddr_i(araddr_i), .arprot_i(3'h0), .rvalid_o(rvalid_o),
        .rready_i(rready_i), .rdata_o(rdata_o), .rresp_o(rresp_o),
        .zero_result_flag_o(zero_result_flag_o), .truncation_flag_o(truncation_flag_o),
        .overflow_flag_o(overflow_flag_o), .operation_error_flag_o(operation_error_flag_o),
        .interrupt_o(interrupt_o));
    // ***********************************************
    // bus and compare tasks
    // ***********************************************
    task automatic final_report;
        if (errors == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic aw_ok, w_ok;
        aw_ok = 0;
        w_ok = 0;
        @(posedge clock_i);
        awaddr_i <= a;
        wdata_i <= d;
        awvalid_i <= 1;
        wvalid_i <= 1;
        while (!(aw_ok && w_ok)) begin
            @(posedge clock_i);
            if (awready_o && !aw_ok) begin
                aw_ok = 1;
                awvalid_i <= 0;
            end
            if (wready_o && !w_ok) begin
                w_ok = 1;
                wvalid_i <= 0;
            end
        end
        // bready comes late on purpose so the response must stand
        do @(posedge clock_i); while (!bvalid_o);
        bready_i <= 1;
        @(posedge clock_i);
        resp = bresp_o;
        bready_i <= 0;
    endtask
    task automatic rdr(input logic [7:0] a);
        @(posedge clock_i);
        araddr_i <= a;
        arvalid_i <= 1;
        do @(posedge clock_i); while (!arready_o);
        arvalid_i <= 0;
        do @(posedge clock_i); while (!rvalid_o);
        rready_i <= 1;
        @(posedge clock_i);
        rd = rdata_o;
        resp = rresp_o;
        rready_i <= 0;
    endtask
    task automatic run(input logic [2:0] op, input logic pulse, input logic [63:0] src);
        wr(SRC_LO_OFFSET, src[31:0]);
        wr(SRC_HI_OFFSET, src[63:32]);
        wr(CTRL_OFFSET, {27'h0, 1'b1, pulse, op}); // destination is the result word, never a counter
        repeat (RW) @(posedge clock_i);
        wr(CTRL_OFFSET, 32'h0);
        repeat (RW) @(posedge clock_i);
    endtask
    task automatic expect_out(input logic [31:0] res, input logic [2:0] fl);
        rdr(RESULT_OFFSET);
        chk("result", res, rd);
        rdr(FLAGS_OFFSET);
        chk("flags", {29'h0, fl}, rd);
        chk("flag pins", {29'h0, fl}, {29'h0, overflow_flag_o, truncation_flag_o, zero_result_flag_o});
    endtask
    task automatic done_after(input logic [31:0] ctrl, input logic [31:0] exp);
        wr(CTRL_OFFSET, ctrl);
        repeat (RW) @(posedge clock_i);
        wr(IRQ_STATUS_OFFSET, 32'h1);
        repeat (RW) @(posedge clock_i);
        rdr(IRQ_STATUS_OFFSET);
        chk("done repeat", exp, rd & 32'h1);
    endtask
    // ***********************************************
    // scenarios
    // ***********************************************
    task automatic test_reset;
        rdr(CTRL_OFFSET);
        chk("ctrl reset", CTRL_RESET, rd);
        rdr(IRQ_MASK_OFFSET);
        chk("mask reset", {29'h0, IRQ_MASK_RESET}, rd);
    endtask
    task automatic test_double;
        run(3'h2, 1, 64'h3ff8_0000_0000_0000);
        expect_out(32'h1, 3'h2);
        run(3'h2, 1, 64'h40e3_8800_0000_0000);
        expect_out(32'h1, 3'h4);
        run(3'h2, 0, 64'hc0e0_0000_0000_0000);
        expect_out(32'h8000, 3'h0);
        run(3'h3, 1, 64'hc004_0000_0000_0000);
        expect_out(32'hffff_fffe, 3'h2);
        run(3'h3, 1, 64'hc1e0_0000_0000_0000);
        expect_out(32'h8000_0000, 3'h0);
        run(3'h3, 0, 64'h0);
        expect_out(32'h0, 3'h1);
        run(3'h3, 1, 64'h41e0_0000_0000_0000);
        expect_out(32'h0, 3'h4);
    endtask
    task automatic test_single;
        run(3'h0, 1, 64'h4000_0000);
        expect_out(32'h2, 3'h0);
        run(3'h1, 0, 64'hc7c3_5060);
        expect_out(32'hfffe_7960, 3'h2);
        run(3'h0, 1, 64'h7f80_0000);
        expect_out(32'hfffe_7960, 3'h2);
        rdr(ERROR_CODE_OFFSET);
        chk("error code", {16'h0, RANGE_ERROR_CODE}, rd);
        chk("error pin", 32'h1, {31'h0, operation_error_flag_o});
    endtask
    task automatic test_moves;
        run(3'h4, 1, 64'h8001);
        rdr(RESULT_OFFSET);
        chk("sign extend", 32'hffff_8001, rd);
        run(3'h5, 1, 64'h8000_1234);
        rdr(RESULT_OFFSET);
        chk("narrow neg", 32'h9234, rd);
        run(3'h5, 1, 64'h7fff_8abc);
        rdr(RESULT_OFFSET);
        chk("narrow pos", 32'h0abc, rd);
    endtask
    task automatic test_scan;
        done_after(32'h1a, 32'h0);
        wr(CTRL_OFFSET, 32'h0);
        repeat (RW) @(posedge clock_i);
        done_after(32'h14, 32'h0);
        done_after(32'h12, 32'h1);
        done_after(32'h0, 32'h0);
    endtask
    task automatic test_irq;
        wr(IRQ_STATUS_OFFSET, 32'h7);
        run(3'h2, 1, 64'h3ff8_0000_0000_0000);
        rdr(IRQ_STATUS_OFFSET);
        chk("done status", 32'h1, rd);
        chk("masked irq", 32'h0, {31'h0, interrupt_o});
        wr(IRQ_MASK_OFFSET, 32'h1);
        repeat (3) @(posedge clock_i);
        chk("irq raised", 32'h1, {31'h0, interrupt_o});
        wr(IRQ_STATUS_OFFSET, 32'h1);
        repeat (3) @(posedge clock_i);
        chk("irq cleared", 32'h0, {31'h0, interrupt_o});
    endtask
    task automatic test_bus;
        wr(8'h40, 32'h1);
        chk("unmapped bresp", {30'h0, RESP_SLVERR}, {30'h0, resp});
        rdr(8'h40);
        chk("unmapped rresp", {30'h0, RESP_SLVERR}, {30'h0, resp});
        chk("unmapped rdata", 32'h0, rd);
        // result is read-only, the write must not land
        wr(RESULT_OFFSET, 32'h5a5a);
        rdr(RESULT_OFFSET);
        chk("result read only", 32'h1, rd);
    endtask
    initial begin
        clock_i = 0;
        forever #2 clock_i = ~clock_i;
    end
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            final_report();
        end
    end
    initial begin
        rst_i = 1;
        {awvalid_i, wvalid_i, bready_i, arvalid_i, rready_i} = 5'h0;
        awaddr_i = 8'h0;
        araddr_i = 8'h0;
        wdata_i = 32'h0;
        wstrb_i = 4'hf;
        repeat (3) @(posedge clock_i);
        rst_i <= 0;
        test_reset();
        test_double();
        test_single();
        test_moves();
        test_scan();
        test_irq();
        test_bus();
        final_report();
    end
endmodule
